/* File: hw/bus_mon_pkg.sv */
// Package for the serial bus monitor block: register offsets, field
// positions, reset values and timing counts.
// Assumes a 200 MHz ref_clk and a plain address/strobe register port.
package bus_mon_pkg;

    // Register port geometry.
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [ADDR_W-1:0] OFS_BUS_DATA  = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_OWN_ADDR  = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_CONTROL   = 2'h2;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 2'h3;

    // Control register fields.
    localparam int CTL_IRQ_EN  = 0;
    localparam int CTL_ACK_EN  = 1;
    localparam int CTL_PRE_LSB = 4;
    localparam int PRE_W       = 2;

    // Status register fields.
    localparam int ST_BYTE_PEND = 7;
    localparam int ST_STOP_SEEN = 5;
    localparam int ST_ADDRESSED = 2;
    localparam int ST_LAST_BIT  = 3;
    localparam int ST_MONITOR   = 1;
    localparam int ST_BUS_IDLE  = 0;

    // Reset values.
    localparam logic [6:0]       OWN_ADDR_RST = 7'h00;
    localparam logic [PRE_W-1:0] PRESCALE_RST = 2'h3;   // Setting for a 12 MHz source clock.

    // Reset filter: a low pulse must last this many source clock cycles.
    localparam int RST_MIN_CYC = 30;
    // Source clock cycle assumed for the filter, in ns, and ref_clk period.
    localparam int SRC_CLK_NS  = 83;
    localparam int REF_CLK_NS  = 5;
    localparam int RST_FILT_CYC = (RST_MIN_CYC * SRC_CLK_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int RST_CNT_W    = 10;

endpackage

/* File: hw/pin_sync.sv */
// Three-stage synchroniser for one asynchronous pin, with agreement check.
// Assumes the pin is unrelated to ref_clk; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst,
    // Pin and filtered level.
    input  wire logic pin_in,
    output logic      level
);
    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // Shift the pin in and update the level when the last two stages agree.
    always_comb begin
        s_nxt       = s_r;
        s_nxt.stage = {s_r.stage[1:0], pin_in};
        if (s_r.stage[1] == s_r.stage[2]) begin
            s_nxt.level = s_r.stage[2];
        end
    end

    // Register the state.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= '{stage: {3{RST_VAL}}, level: RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.level;
endmodule

/* File: hw/bus_mon.sv */
// What this block does
// - Own address all zero enters monitor mode.
// - Monitor mode counts every transfer as selected.
// - Monitor mode stays slave receiver, never transmits.
// - Monitor mode never drives acknowledge low.
// - Monitor mode never raises interrupt request.
// - Monitor mode never stretches the serial clock.
// - Each monitored byte lands in receive buffer.
// - Pending flag clears after ack, sets next.
// - Prescaler resets to the 12 MHz setting.
// - Reset accepted only after thirty-clock low pulse.
// - Reset clears flags, sets byte-pending and bus-idle flags.
//
// Serial bus controller slave receiver with passive monitor mode.
// Assumes SCL/SDA pins are asynchronous; register port is on ref_clk.
`timescale 1ns/1ps
module bus_mon
    import bus_mon_pkg::*;
#(
    parameter int RST_FILT = RST_FILT_CYC
) (
    // Clock and resets.
    input  wire logic                           ref_clk,
    input  wire logic                           rst,
    input  wire logic                           ext_reset_n,
    // Register port.
    input  wire logic [bus_mon_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [bus_mon_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [bus_mon_pkg::DATA_W-1:0] reg_rdata,
    // Serial bus pins.
    input  wire logic                           scl_in,
    output logic                                scl_out,
    output logic                                scl_oe,
    input  wire logic                           sda_in,
    output logic                                sda_out,
    output logic                                sda_oe,
    // Interrupt request, active low.
    output logic                                irq_n
);
    import bus_mon_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA,
        ST_ACK,
        ST_SKIP
    } rx_state_t;

    typedef struct packed {
        rx_state_t          st;
        logic               scl_q;
        logic               sda_q;
        logic [3:0]         bit_cnt;
        logic [7:0]         shift;
        logic               first_byte;
        logic               selected;
        logic               ack_drive;
        logic               hold_scl;
        logic [6:0]         own_address_reg;
        logic [7:0]         bus_data_reg;
        logic               irq_output_enable;
        logic               ack_en;
        logic [PRE_W-1:0]   prescale;
        logic               byte_pend;
        logic               stop_seen;
        logic               addressed;
        logic               last_bit;
        logic               bus_idle_flag;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic               ext_rst_fire;
        logic [DATA_W-1:0]  rdata;
        logic               irq_n;
    } mon_state_t;

    mon_state_t s_r;
    mon_state_t s_nxt;

    logic scl_s;
    logic sda_s;
    logic rstn_s;
    logic monitor;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] status;

    // Synchronise the two bus lines and the external reset pin.
    pin_sync #(.RST_VAL(1'b1)) u_scl_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin_in  (scl_in),
        .level   (scl_s)
    );
    pin_sync #(.RST_VAL(1'b1)) u_sda_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin_in  (sda_in),
        .level   (sda_s)
    );
    pin_sync #(.RST_VAL(1'b1)) u_rst_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin_in  (ext_reset_n),
        .level   (rstn_s)
    );

    // Monitor mode and bus line events.
    assign monitor    = (s_r.own_address_reg == 7'h00);
    assign scl_rise   = scl_s & ~s_r.scl_q;
    assign scl_fall   = ~scl_s & s_r.scl_q;
    assign start_cond = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s;
    assign stop_cond  = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s;

    // Status byte as software reads it.
    always_comb begin
        status               = 8'h00;
        status[ST_BYTE_PEND] = s_r.byte_pend;
        status[ST_STOP_SEEN] = s_r.stop_seen;
        status[ST_LAST_BIT]  = s_r.last_bit;
        status[ST_ADDRESSED] = s_r.addressed;
        status[ST_MONITOR]   = monitor;
        status[ST_BUS_IDLE]  = s_r.bus_idle_flag;
    end

    // Receiver, register port and reset filter.
    always_comb begin
        s_nxt              = s_r;
        s_nxt.scl_q        = scl_s;
        s_nxt.sda_q        = sda_s;
        s_nxt.ext_rst_fire = 1'b0;

        // Bus idle tracking holds in every mode.
        if (start_cond) begin
            s_nxt.bus_idle_flag = 1'b0;
        end else if (stop_cond) begin
            s_nxt.bus_idle_flag = 1'b1;
        end

        case (s_r.st)
            ST_IDLE: begin
                s_nxt.ack_drive = 1'b0;
            end
            ST_DATA: begin
                if (scl_rise) begin
                    s_nxt.shift   = {s_r.shift[6:0], sda_s};
                    s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    if (s_r.bit_cnt == 4'h0 && monitor) begin
                        s_nxt.byte_pend = 1'b1;
                    end
                end
                if (scl_fall && s_r.bit_cnt == 4'h8) begin
                    s_nxt.bit_cnt = 4'h0;
                    s_nxt.st      = ST_ACK;
                    if (s_r.first_byte) begin
                        s_nxt.selected  = monitor || (s_r.shift[7:1] == s_r.own_address_reg)
                                          || (s_r.shift == 8'h00);
                        s_nxt.addressed = s_nxt.selected;
                    end
                    if (s_nxt.selected) begin
                        s_nxt.bus_data_reg = s_r.shift;
                        s_nxt.ack_drive    = s_r.ack_en && !monitor;
                    end
                    if (!s_nxt.selected) begin
                        s_nxt.st = ST_SKIP;
                    end
                end
            end
            ST_ACK: begin
                if (scl_rise) begin
                    s_nxt.last_bit = sda_s;
                end
                if (scl_fall) begin
                    s_nxt.ack_drive  = 1'b0;
                    s_nxt.first_byte = 1'b0;
                    s_nxt.byte_pend  = 1'b0;
                    s_nxt.hold_scl   = !monitor;
                    s_nxt.st         = ST_DATA;
                end
            end
            ST_SKIP: begin
                s_nxt.ack_drive = 1'b0;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        // Start or stop conditions restart byte framing.
        if (start_cond) begin
            s_nxt.st         = ST_DATA;
            s_nxt.bit_cnt    = 4'h0;
            s_nxt.first_byte = 1'b1;
            s_nxt.selected   = 1'b0;
            s_nxt.ack_drive  = 1'b0;
        end else if (stop_cond) begin
            s_nxt.st        = ST_IDLE;
            s_nxt.ack_drive = 1'b0;
            s_nxt.hold_scl  = 1'b0;
            if (s_r.selected) begin
                s_nxt.stop_seen = 1'b1;
            end
        end

        // Monitor mode never holds the clock; in normal mode software releases it by reading data.
        if (monitor) begin
            s_nxt.hold_scl = 1'b0;
        end

        // Register reads; outside monitor mode a data register read re-arms the pending flag.
        s_nxt.rdata = s_r.rdata;
        if (reg_rd) begin
            case (reg_addr)
                OFS_BUS_DATA: begin
                    s_nxt.rdata = s_r.bus_data_reg;
                    if (!monitor) begin
                        s_nxt.byte_pend = 1'b1;
                        s_nxt.hold_scl  = 1'b0;
                    end
                end
                OFS_OWN_ADDR: s_nxt.rdata = {1'b0, s_r.own_address_reg};
                OFS_CONTROL: begin
                    s_nxt.rdata = 8'h00;
                    s_nxt.rdata[CTL_IRQ_EN] = s_r.irq_output_enable;
                    s_nxt.rdata[CTL_ACK_EN] = s_r.ack_en;
                    s_nxt.rdata[CTL_PRE_LSB +: PRE_W] = s_r.prescale;
                end
                OFS_STATUS:  s_nxt.rdata = status;
                default:     s_nxt.rdata = 8'h00;
            endcase
        end

        // Register writes.
        if (reg_wr) begin
            case (reg_addr)
                OFS_OWN_ADDR: s_nxt.own_address_reg = reg_wdata[6:0];
                OFS_CONTROL: begin
                    s_nxt.irq_output_enable = reg_wdata[CTL_IRQ_EN];
                    s_nxt.ack_en            = reg_wdata[CTL_ACK_EN];
                    s_nxt.prescale          = reg_wdata[CTL_PRE_LSB +: PRE_W];
                end
                default: begin
                end
            endcase
        end

        // Interrupt when a byte completes, suppressed in monitor mode.
        s_nxt.irq_n = ~(s_r.irq_output_enable && !s_r.byte_pend && !monitor);

        // External reset filter: only a long enough low pulse resets.
        if (rstn_s) begin
            s_nxt.rst_cnt = '0;
        end else if (s_r.rst_cnt != RST_CNT_W'(RST_FILT)) begin
            s_nxt.rst_cnt = s_r.rst_cnt + 1'b1;
            if (s_r.rst_cnt == RST_CNT_W'(RST_FILT - 1)) begin
                s_nxt.ext_rst_fire = 1'b1;
            end
        end
    end

    // Register the state; both resets give the same defined state, except that only rst clears rst_cnt.
    always_ff @(posedge ref_clk) begin
        if (rst || s_r.ext_rst_fire) begin
            s_r <= '{st: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, bit_cnt: 4'h0,
                     shift: 8'h00, first_byte: 1'b0, selected: 1'b0,
                     ack_drive: 1'b0, hold_scl: 1'b0, own_address_reg: OWN_ADDR_RST,
                     bus_data_reg: 8'h00, irq_output_enable: 1'b0, ack_en: 1'b0,
                     prescale: PRESCALE_RST,
                     byte_pend: 1'b1, stop_seen: 1'b0, addressed: 1'b0,
                     last_bit: 1'b0, bus_idle_flag: 1'b1,
                     rst_cnt: (rst ? '0 : s_r.rst_cnt), ext_rst_fire: 1'b0,
                     rdata: 8'h00, irq_n: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pins only ever pull low; outputs come straight from flip-flops.
    assign reg_rdata = s_r.rdata;
    assign scl_out   = 1'b0;
    assign scl_oe    = s_r.hold_scl;
    assign sda_out   = 1'b0;
    assign sda_oe    = s_r.ack_drive;
    assign irq_n     = s_r.irq_n;
endmodule

/* File: verification/bus_mon_monitor.sv */
// Checker for the serial bus monitor block, watching top-level ports only.
// Assumes every port lives on ref_clk and rst is synchronous, active high.
`timescale 1ns/1ps
module bus_mon_monitor
    import bus_mon_pkg::*;
(
    // Clock and reset.
    input wire logic                           ref_clk,
    input wire logic                           rst,
    // Register port.
    input wire logic [bus_mon_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [bus_mon_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                           reg_wr,
    input wire logic                           reg_rd,
    input wire logic [bus_mon_pkg::DATA_W-1:0] reg_rdata,
    // Serial bus and interrupt.
    input wire logic                           sda_in,
    input wire logic                           scl_oe,
    input wire logic                           sda_oe,
    input wire logic                           irq_n
);
    logic [6:0] own_r;
    logic       fresh_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Shadows the own address and notes whether state is still as reset left it.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            own_r   <= 7'h00;
            fresh_r <= 1'b1;
        end else begin
            if (reg_wr && reg_addr == OFS_OWN_ADDR) begin
                own_r <= reg_wdata[6:0];
            end
            if (reg_wr || !sda_in) begin
                fresh_r <= 1'b0;
            end
        end
    end
    property p_no_ack;
        (own_r == 7'h00) [*2] |-> !sda_oe;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("ack driven in monitor");
    property p_no_irq;
        own_r == 7'h00 && $stable(own_r) |-> irq_n;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("irq in monitor");
    property p_no_stretch;
        $rose(scl_oe) |-> $past(own_r) != 7'h00;
    endproperty
    a_no_stretch: assert property (p_no_stretch) else $error("clock held in monitor");
    property p_no_drive;
        $rose(sda_oe) |-> $past(own_r, 2) != 7'h00;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("data driven in monitor");
    property p_own_read;
        reg_rd && reg_addr == OFS_OWN_ADDR |=> reg_rdata[6:0] == own_r;
    endproperty
    a_own_read: assert property (p_own_read) else $error("own address readback");
    property p_rst_flags;
        reg_rd && fresh_r && reg_addr == OFS_STATUS |=>
            reg_rdata[ST_BYTE_PEND] && !reg_rdata[ST_STOP_SEEN] && !reg_rdata[ST_ADDRESSED];
    endproperty
    a_rst_flags: assert property (p_rst_flags) else $error("status after reset");
    property p_rst_pre;
        reg_rd && fresh_r && reg_addr == OFS_CONTROL |=> reg_rdata[5:4] == PRESCALE_RST;
    endproperty
    a_rst_pre: assert property (p_rst_pre) else $error("prescale after reset");
    property p_rst_pins;
        $fell(rst) |-> irq_n && !sda_oe && !scl_oe;
    endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pins after reset");
endmodule

bind bus_mon bus_mon_monitor i_mon (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .sda_in, .scl_oe, .sda_oe, .irq_n);

/* File: verification/bus_master_model.sv */
// Serial bus master model driving open-drain clock and data lines.
// Assumes pull-ups on both lines; a released line reads high.
`timescale 1ns/1ps
module bus_master_model (
    // Clock.
    input  wire logic ref_clk,
    // Wire levels and pull-down enables.
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_low,
    output logic      sda_low
);
    int half = 20;
    // Both lines start released so the bus is idle.
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // Waits a number of clock edges.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Data falls while the clock is high.
    task automatic start_cond();
        sda_low <= 1'b1;
        tick(half);
        scl_low <= 1'b1;
        tick(half);
    endtask
    // Sends the top n bits; a held clock line is waited out.
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            sda_low <= !b[i];
            tick(half);
            scl_low <= 1'b0;
            tick(1);
            wait (scl_line);
            tick(half);
            scl_low <= 1'b1;
        end
    endtask
    // Releases data for the ninth clock and reports whether it was pulled low.
    task automatic ack_slot(output logic acked);
        sda_low <= 1'b0;
        tick(half);
        scl_low <= 1'b0;
        tick(1);
        wait (scl_line);
        tick(half);
        acked = !sda_line;
        scl_low <= 1'b1;
    endtask
    // Data rises while the clock is high.
    task automatic stop_cond();
        sda_low <= 1'b1;
        tick(half);
        scl_low <= 1'b0;
        tick(half);
        sda_low <= 1'b0;
        tick(half);
    endtask
endmodule

/* File: verification/bus_mon_test.sv */
// Self-checking bench for the serial bus monitor block.
// Assumes the package constants and a shortened reset filter of 8 cycles.
`timescale 1ns/1ps
module bus_mon_test;
    import bus_mon_pkg::*;
    logic              ref_clk, rst, ext_reset_n, reg_wr, reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
    logic              scl_oe, sda_oe, irq_n, m_scl, m_sda, ack;
    logic [7:0]        seq [3] = '{8'hA5, 8'h3C, 8'h00};
    int                miscompares = 0, checks_done = 0, gap = 6;
    // Open-drain lines with pull-ups.
    wire logic         scl_w = !(scl_oe || m_scl);
    wire logic         sda_w = !(sda_oe || m_sda);
    bus_mon #(.RST_FILT(8)) i_dut (.ref_clk, .rst, .ext_reset_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .scl_in(scl_w), .scl_out(), .scl_oe, .sda_in(sda_w),
        .sda_out(), .sda_oe, .irq_n);
    bus_master_model i_bus (.ref_clk, .scl_line(scl_w), .sda_line(sda_w), .scl_low(m_scl),
        .sda_low(m_sda));
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Register write, then idle so strobes stay gap cycles apart.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        repeat (gap - 1) @(posedge ref_clk);
    endtask
    // Register read; data are taken in the cycle after the strobe.
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
        repeat (gap - 2) @(posedge ref_clk);
    endtask
    // Reset values, read with strobes three cycles apart.
    task automatic t_reset_vals();
        gap = 3;
        rd(OFS_STATUS, rv);
        chk(rv & 8'hA5, 8'h81);
        rd(OFS_CONTROL, rv);
        chk(rv & 8'h33, 8'h30);
        rd(OFS_OWN_ADDR, rv);
        chk(rv & 8'h7F, 8'h00);
        gap = 6;
    endtask
    // Monitoring a read transfer with ack and interrupt enabled.
    task automatic t_monitor();
        wr(OFS_CONTROL, 8'h33);
        i_bus.start_cond();
        rd(OFS_STATUS, rv);
        chk({7'h00, rv[ST_BUS_IDLE]}, 8'h00);
        foreach (seq[i]) begin
            i_bus.send_bits(seq[i], 1);
            rd(OFS_STATUS, rv);
            chk({7'h00, rv[ST_BYTE_PEND]}, 8'h01);
            i_bus.send_bits(seq[i] << 1, 7);
            i_bus.ack_slot(ack);
            chk({7'h00, ack}, 8'h00);
            chk({7'h00, irq_n}, 8'h01);
            repeat (10) @(posedge ref_clk);
            chk({7'h00, scl_oe}, 8'h00);
            rd(OFS_STATUS, rv);
            chk({7'h00, rv[ST_BYTE_PEND]}, 8'h00);
            rd(OFS_BUS_DATA, rv);
            chk(rv, seq[i]);
        end
        i_bus.stop_cond();
        rd(OFS_STATUS, rv);
        chk({7'h00, rv[ST_BUS_IDLE]}, 8'h01);
    endtask
    // Nonzero own address: the matching address is acknowledged.
    task automatic t_normal();
        i_bus.half = 8;
        wr(OFS_OWN_ADDR, 8'h2A);
        // A data read re-arms the pending flag, so the interrupt must be quiet first.
        rd(OFS_BUS_DATA, rv);
        chk({7'h00, irq_n}, 8'h01);
        i_bus.start_cond();
        i_bus.send_bits(8'h54, 8);
        i_bus.ack_slot(ack);
        chk({7'h00, ack}, 8'h01);
        repeat (10) @(posedge ref_clk);
        chk({7'h00, irq_n}, 8'h00);
        chk({7'h00, scl_oe}, 8'h01);
        rd(OFS_BUS_DATA, rv);
        chk(rv, 8'h54);
        i_bus.stop_cond();
        wr(OFS_OWN_ADDR, 8'h00);
        i_bus.half = 20;
    endtask
    // Pulls the reset pin low for n cycles.
    task automatic pulse(input int n);
        ext_reset_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        ext_reset_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
    endtask
    // A short pin pulse is filtered out; a long one resets.
    task automatic t_ext_reset();
        wr(OFS_CONTROL, 8'h00);
        pulse(4);
        rd(OFS_CONTROL, rv);
        chk(rv & 8'h33, 8'h00);
        pulse(20);
        rd(OFS_CONTROL, rv);
        chk(rv & 8'h33, 8'h30);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Clock of 5 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = !ref_clk;
    end
    // Main sequence.
    initial begin
        rst = 1'b1;
        ext_reset_n = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset_vals();
        t_monitor();
        t_normal();
        t_ext_reset();
        summarize();
    end
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        summarize();
    end
endmodule
